// *** hw/uic_irq_clear_id.sv ***
// Interrupt clear, mask, status and upper identification registers of a UART.
// Assumes a same-clock register master and one-cycle event pulses from the UART.
//
// Functional notes
// - Writing one clears raw and masked status.
// - Writing zero leaves the interrupt unchanged.
// - Bit 10 clears overrun, bit 9 break.
// - Bit 8 clears parity, bit 7 framing.
// - Bits 6,5,4 clear timeout, transmit, receive.
// - Clear register reserved bits ignored, read zero.
// - Identification registers fixed, read-only, low byte.
// - Registers four to seven give identifier bytes.
// - Raw and masked status readable, writes ignored.
// - Interrupt output only when mask bit set.
`timescale 1ns/1ps
module uic_irq_clear_id #(
  // Identifier returned one byte per register; the value is arbitrary.
  parameter logic [31:0] PERIPH_ID = uic_pkg::ID_DEFAULT,
  // Number of interrupt sources handled.
  parameter int EVT_N = uic_pkg::EVT_N
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [uic_pkg::ADDR_W-1:0] regAddr,
  input wire logic [uic_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [uic_pkg::DATA_W-1:0] regRdData,
  input wire logic [EVT_N-1:0] evtPulse,
  output logic [EVT_N-1:0] intMask,
  output logic irqOut
);

  // The decode below is laid out for the seven documented sources.
  if (EVT_N != uic_pkg::EVT_N) begin : g_chk
    $error("uic_irq_clear_id: EVT_N must be seven");
  end

  // Channel to the status latch.
  uic_stat_if #(.N(EVT_N)) stat ();

  // Mask register, also sent back to the UART.
  logic [EVT_N-1:0] mask_q;
  // Next mask value.
  logic [EVT_N-1:0] mask_d;
  // Registered read data, valid only in the cycle after a read.
  logic [uic_pkg::DATA_W-1:0] rdData_q;
  // Next read data.
  logic [uic_pkg::DATA_W-1:0] rdData_d;
  // Registered interrupt request.
  logic irq_q;
  // Next interrupt request.
  logic irq_d;

  // Decoded write targets.
  logic wrClear;
  logic wrMask;
  // Clear pulses per source.
  logic [EVT_N-1:0] clrHit;
  // Masked status as seen by software.
  logic [EVT_N-1:0] masked;

  // Address decode for writes. Writes to status and identification
  // registers fall through with no effect.
  always_comb begin
    wrClear = regWrEn && (regAddr == uic_pkg::OFF_CLEAR);
    wrMask = regWrEn && (regAddr == uic_pkg::OFF_MASK);
  end

  // Clear pulse decode. Only the seven clear fields are looked at, so
  // reserved bits written by mistake cannot disturb anything.
  always_comb begin
    clrHit = '0;
    if (wrClear) begin
      clrHit[uic_pkg::IDX_OVR] = regWrData[uic_pkg::BIT_OVR_CLR];
      clrHit[uic_pkg::IDX_BRK] = regWrData[uic_pkg::BIT_BRK_CLR];
      clrHit[uic_pkg::IDX_PAR] = regWrData[uic_pkg::BIT_PAR_CLR];
      clrHit[uic_pkg::IDX_FRM] = regWrData[uic_pkg::BIT_FRM_CLR];
      clrHit[uic_pkg::IDX_RTO] = regWrData[uic_pkg::BIT_RTO_CLR];
      clrHit[uic_pkg::IDX_TX] = regWrData[uic_pkg::BIT_TX_CLR];
      clrHit[uic_pkg::IDX_RX] = regWrData[uic_pkg::BIT_RX_CLR];
    end
  end

  // Feed the latch. The latch gives set priority over clear.
  assign stat.evtSet = evtPulse;
  assign stat.clrHit = clrHit;

  // Sticky raw status latch.
  uic_event_latch #(.N(EVT_N)) u_latch (
    .core_clk(core_clk),
    .rst(rst),
    .st(stat.latch)
  );

  // Masked view follows the raw bit, so a clear removes both at once.
  always_comb begin
    masked = stat.raw & mask_q;
  end

  // Mask next value; the mask is a plain read/write field.
  always_comb begin
    mask_d = mask_q;
    if (wrMask) begin
      mask_d = regWrData[uic_pkg::EVT_LSB +: EVT_N];
    end
  end

  // Interrupt request next value. Built from next raw and next mask so that
  // the output flip-flop lines up with the status flip-flops, with no lag.
  always_comb begin
    irq_d = |(stat.rawNext & mask_d);
  end

  // Read data next value. Anything not a read, or an unmapped address,
  // returns zero so the bus never sees stale data.
  always_comb begin
    rdData_d = uic_pkg::RD_IDLE;
    if (regRdEn) begin
      case (regAddr)
        uic_pkg::OFF_MASK: begin
          rdData_d[uic_pkg::EVT_LSB +: EVT_N] = mask_q;
        end
        uic_pkg::OFF_RAW: begin
          rdData_d[uic_pkg::EVT_LSB +: EVT_N] = stat.raw;
          rdData_d[uic_pkg::EVT_LSB-1:0] = uic_pkg::RAW_LOW_RSVD;
        end
        uic_pkg::OFF_MASKED: begin
          rdData_d[uic_pkg::EVT_LSB +: EVT_N] = masked;
        end
        uic_pkg::OFF_CLEAR: begin
          rdData_d = uic_pkg::RD_IDLE;
        end
        uic_pkg::OFF_ID4: begin
          rdData_d[uic_pkg::ID_LSB +: uic_pkg::ID_W] = PERIPH_ID[7:0];
        end
        uic_pkg::OFF_ID5: begin
          rdData_d[uic_pkg::ID_LSB +: uic_pkg::ID_W] = PERIPH_ID[15:8];
        end
        uic_pkg::OFF_ID6: begin
          rdData_d[uic_pkg::ID_LSB +: uic_pkg::ID_W] = PERIPH_ID[23:16];
        end
        uic_pkg::OFF_ID7: begin
          rdData_d[uic_pkg::ID_LSB +: uic_pkg::ID_W] = PERIPH_ID[31:24];
        end
        default: begin
          // Unmapped addresses read as zero.
          rdData_d = uic_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Register all state. The identifiers are constants, so no write path
  // exists that could ever change them.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_q <= uic_pkg::MASK_RST;
      rdData_q <= uic_pkg::RD_IDLE;
      irq_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      rdData_q <= rdData_d;
      irq_q <= irq_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign regRdData = rdData_q;
  assign intMask = mask_q;
  assign irqOut = irq_q;

  // A clear of a set bit with no new event removes the raw status.
  a_clear_drops_raw: assert property (@(posedge core_clk) disable iff (rst)
    (clrHit & ~evtPulse & stat.raw) != '0 |=> (stat.raw & $past(clrHit & ~evtPulse)) == '0)
    else $error("clear write left raw status set");

  // A clear write with the overrun bit drops the overrun status.
  a_overrun_clear_map: assert property (@(posedge core_clk) disable iff (rst)
    wrClear && regWrData[10] && !evtPulse[6] |=> !stat.raw[6] && !masked[6])
    else $error("bit 10 did not clear overrun");

  // A clear write with bit 8 drops the parity status.
  a_parity_clear_map: assert property (@(posedge core_clk) disable iff (rst)
    wrClear && regWrData[8] && !evtPulse[4] |=> !stat.raw[4])
    else $error("bit 8 did not clear parity");

  // A clear write with bit 4 drops the receive status.
  a_receive_clear_map: assert property (@(posedge core_clk) disable iff (rst)
    wrClear && regWrData[4] && !evtPulse[0] |=> !stat.raw[0])
    else $error("bit 4 did not clear receive");

  // Reserved clear bits alone never disturb any status.
  a_reserved_clear_idle: assert property (@(posedge core_clk) disable iff (rst)
    wrClear && regWrData[10:4] == 7'h00 |=> stat.raw == $past(stat.raw | evtPulse))
    else $error("reserved clear bits changed status");

  // Reading the clear register returns zero.
  a_clear_reads_zero: assert property (@(posedge core_clk) disable iff (rst)
    regRdEn && regAddr == uic_pkg::OFF_CLEAR |=> rdData_q == 32'h0000_0000)
    else $error("clear register read not zero");

  // The top identifier register returns only its byte, zero above.
  a_id_top_byte: assert property (@(posedge core_clk) disable iff (rst)
    regRdEn && regAddr == uic_pkg::OFF_ID7 |=> rdData_q == {24'h000000, PERIPH_ID[31:24]})
    else $error("identifier byte seven wrong");

  // The lowest identifier register returns the low byte.
  a_id_low_byte: assert property (@(posedge core_clk) disable iff (rst)
    regRdEn && regAddr == uic_pkg::OFF_ID4 |=> rdData_q[7:0] == PERIPH_ID[7:0] && rdData_q[31:8] == 24'h000000)
    else $error("identifier byte four wrong");

  // Raw status read shows the latch as it stood at the read.
  a_raw_read_view: assert property (@(posedge core_clk) disable iff (rst)
    regRdEn && regAddr == uic_pkg::OFF_RAW |=> rdData_q == {21'h0, $past(stat.raw), 4'hF})
    else $error("raw status read mismatch");

  // Writes to the status registers leave the mask untouched.
  a_status_write_void: assert property (@(posedge core_clk) disable iff (rst)
    regWrEn && (regAddr == uic_pkg::OFF_RAW || regAddr == uic_pkg::OFF_MASKED) |=> mask_q == $past(mask_q))
    else $error("status write changed state");

  // The interrupt output tracks unmasked status in the same cycle.
  a_irq_needs_mask: assert property (@(posedge core_clk) disable iff (rst)
    irqOut == ((stat.raw & mask_q) != '0))
    else $error("interrupt output disagrees with masked status");

  // Read data are zero in any cycle not following a read.
  a_read_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    !regRdEn |=> rdData_q == 32'h0000_0000)
    else $error("read data stood too long");

  // Per-field clear checks for the sources not covered above. Each one
  // leaves out a same-cycle event, because set wins over clear.

  // A clear write with bit 9 drops the break status.
  a_break_clear_map: assert property (@(posedge core_clk) disable iff (rst)
    wrClear && regWrData[uic_pkg::BIT_BRK_CLR] && !evtPulse[uic_pkg::IDX_BRK] |=> !stat.raw[uic_pkg::IDX_BRK])
    else $error("bit 9 did not clear break");

  // A clear write with bit 7 drops the framing status.
  a_framing_clear_map: assert property (@(posedge core_clk) disable iff (rst)
    wrClear && regWrData[uic_pkg::BIT_FRM_CLR] && !evtPulse[uic_pkg::IDX_FRM] |=> !stat.raw[uic_pkg::IDX_FRM])
    else $error("bit 7 did not clear framing");

  // A clear write with bit 6 drops the receive time-out status.
  a_timeout_clear_map: assert property (@(posedge core_clk) disable iff (rst)
    wrClear && regWrData[uic_pkg::BIT_RTO_CLR] && !evtPulse[uic_pkg::IDX_RTO] |=> !stat.raw[uic_pkg::IDX_RTO])
    else $error("bit 6 did not clear timeout");

  // A clear write with bit 5 drops the transmit status.
  a_transmit_clear_map: assert property (@(posedge core_clk) disable iff (rst)
    wrClear && regWrData[uic_pkg::BIT_TX_CLR] && !evtPulse[uic_pkg::IDX_TX] |=> !stat.raw[uic_pkg::IDX_TX])
    else $error("bit 5 did not clear transmit");

  // Fields written as zero in a clear write keep their status and still take events.
  // This is checked against the decoded clear pulses, the latch's own inputs, not the register word.
  a_zero_bits_keep: assert property (@(posedge core_clk) disable iff (rst)
    wrClear |=> (stat.raw & ~$past(clrHit)) == ($past(stat.raw | evtPulse) & ~$past(clrHit)))
    else $error("zero clear bit changed status");

  // A clear with no new event also removes the masked view of that source.
  a_clear_drops_masked: assert property (@(posedge core_clk) disable iff (rst)
    (clrHit & ~evtPulse) != '0 |=> (masked & $past(clrHit & ~evtPulse)) == '0)
    else $error("clear write left masked status set");

  // Every event shows up in raw status one cycle later, mask or not.
  a_event_sets_raw: assert property (@(posedge core_clk) disable iff (rst)
    evtPulse != '0 |=> (stat.raw & $past(evtPulse)) == $past(evtPulse))
    else $error("event not latched in raw status");

  // Masked status read shows the masked view as it stood at the read.
  a_masked_read_view: assert property (@(posedge core_clk) disable iff (rst)
    regRdEn && regAddr == uic_pkg::OFF_MASKED |=> rdData_q == {21'h0, $past(masked), 4'h0})
    else $error("masked status read mismatch");

  // Mask read returns the mask in the same bit layout as the clear fields.
  a_mask_read_view: assert property (@(posedge core_clk) disable iff (rst)
    regRdEn && regAddr == uic_pkg::OFF_MASK |=> rdData_q == {21'h0, $past(mask_q), 4'h0})
    else $error("mask read mismatch");

  // Identifier register five returns bits 15:8 of the identifier.
  a_id_byte_five: assert property (@(posedge core_clk) disable iff (rst)
    regRdEn && regAddr == uic_pkg::OFF_ID5 |=> rdData_q == {24'h000000, PERIPH_ID[15:8]})
    else $error("identifier byte five wrong");

  // Identifier register six returns bits 23:16 of the identifier.
  a_id_byte_six: assert property (@(posedge core_clk) disable iff (rst)
    regRdEn && regAddr == uic_pkg::OFF_ID6 |=> rdData_q == {24'h000000, PERIPH_ID[23:16]})
    else $error("identifier byte six wrong");

  // Writes at or above the identifier block touch neither mask nor status.
  // A stray decode there would let software corrupt state by probing the map.
  a_id_write_void: assert property (@(posedge core_clk) disable iff (rst)
    regWrEn && regAddr >= uic_pkg::OFF_ID4 |=> mask_q == $past(mask_q) && stat.raw == $past(stat.raw | evtPulse))
    else $error("identifier write changed state");

  // Writes to the status registers never clear the raw status.
  a_status_write_raw: assert property (@(posedge core_clk) disable iff (rst)
    regWrEn && (regAddr == uic_pkg::OFF_RAW || regAddr == uic_pkg::OFF_MASKED) |=> stat.raw == $past(stat.raw | evtPulse))
    else $error("status write changed raw status");

  // An all-zero mask silences the interrupt output from the next cycle on.
  a_zero_mask_quiet: assert property (@(posedge core_clk) disable iff (rst)
    wrMask && regWrData[uic_pkg::EVT_LSB +: EVT_N] == '0 |=> !irqOut)
    else $error("interrupt raised with all sources masked");

  // A mask write reaches the mask output one cycle later.
  a_mask_write_lands: assert property (@(posedge core_clk) disable iff (rst)
    wrMask |=> intMask == $past(regWrData[uic_pkg::EVT_LSB +: EVT_N]))
    else $error("mask write did not land");

  // An event on an enabled source raises the output with no extra lag.
  // The output flop is fed from next values so that it cannot trail status.
  a_irq_on_unmasked: assert property (@(posedge core_clk) disable iff (rst)
    (evtPulse & mask_q) != '0 && !wrMask |=> irqOut)
    else $error("unmasked event did not raise interrupt");

  // Seen from the register side, an event beats its own clear.
  a_set_wins_top: assert property (@(posedge core_clk) disable iff (rst)
    (evtPulse & clrHit) != '0 |=> (stat.raw & $past(evtPulse & clrHit)) == $past(evtPulse & clrHit))
    else $error("event lost under clear write");

  // Reserved upper bits of every read are zero.
  a_read_upper_zero: assert property (@(posedge core_clk) disable iff (rst)
    regRdEn |=> rdData_q[31:11] == 21'h0)
    else $error("reserved read bits not zero");

endmodule

// *** hw/uic_pkg.sv ***
// Constants shared by the interrupt clear and identification block.
// Assumes a 12-bit word-aligned register address and 32-bit register data.
package uic_pkg;

  // Register bus widths.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [11:0] OFF_MASK = 12'h038;
  localparam logic [11:0] OFF_RAW = 12'h03C;
  localparam logic [11:0] OFF_MASKED = 12'h040;
  localparam logic [11:0] OFF_CLEAR = 12'h044;
  localparam logic [11:0] OFF_ID4 = 12'hFD0;
  localparam logic [11:0] OFF_ID5 = 12'hFD4;
  localparam logic [11:0] OFF_ID6 = 12'hFD8;
  localparam logic [11:0] OFF_ID7 = 12'hFDC;

  // Number of interrupt sources and the register bit of the lowest one.
  localparam int EVT_N = 7;
  localparam int EVT_LSB = 4;

  // Index of each source inside the seven-bit event vector.
  localparam int IDX_RX = 0;
  localparam int IDX_TX = 1;
  localparam int IDX_RTO = 2;
  localparam int IDX_FRM = 3;
  localparam int IDX_PAR = 4;
  localparam int IDX_BRK = 5;
  localparam int IDX_OVR = 6;

  // Register bit of each clear field.
  localparam int BIT_OVR_CLR = 10;
  localparam int BIT_BRK_CLR = 9;
  localparam int BIT_PAR_CLR = 8;
  localparam int BIT_FRM_CLR = 7;
  localparam int BIT_RTO_CLR = 6;
  localparam int BIT_TX_CLR = 5;
  localparam int BIT_RX_CLR = 4;

  // Identification byte field position and width.
  localparam int ID_LSB = 0;
  localparam int ID_W = 8;

  // Values after reset and fixed read values.
  localparam logic [6:0] RAW_RST = 7'h00;
  localparam logic [6:0] MASK_RST = 7'h00;
  localparam logic [3:0] RAW_LOW_RSVD = 4'hF;
  localparam logic [31:0] RD_IDLE = 32'h0000_0000;

  // Identifier default; the value is arbitrary.
  localparam logic [31:0] ID_DEFAULT = 32'h5A3C_96E1;

endpackage

// *** hw/uic_stat_if.sv ***
// Interface between the register front end and the event latch.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface uic_stat_if #(
  parameter int N = 7
);
  // One-cycle event pulses from the UART datapath.
  logic [N-1:0] evtSet;
  // One-cycle clear pulses decoded from a clear write.
  logic [N-1:0] clrHit;
  // Latched raw status and its next value.
  logic [N-1:0] raw;
  logic [N-1:0] rawNext;

  // Front end drives events and clears, reads status.
  modport ctrl (output evtSet, output clrHit, input raw, input rawNext);
  // Latch takes events and clears, returns status.
  modport latch (input evtSet, input clrHit, output raw, output rawNext);
endinterface

// *** hw/uic_event_latch.sv ***
// Sticky raw interrupt status, one bit per source.
// Assumes events and clears are one-cycle pulses on core_clk.
`timescale 1ns/1ps
module uic_event_latch #(
  parameter int N = 7
) (
  input wire logic core_clk,
  input wire logic rst,
  uic_stat_if.latch st
);

  // The front end decodes exactly the documented source count.
  if (N != uic_pkg::EVT_N) begin : g_chk
    $error("uic_event_latch: N must match the source count");
  end

  // Registered raw status.
  logic [N-1:0] raw_q;
  // Next raw status.
  logic [N-1:0] raw_d;

  // Per-bit next value: an event wins over a clear in the same cycle.
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_comb begin
      raw_d[i] = st.evtSet[i] | (raw_q[i] & ~st.clrHit[i]);
    end
  end

  // Register the status bits.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      raw_q <= uic_pkg::RAW_RST[N-1:0];
    end else begin
      raw_q <= raw_d;
    end
  end

  assign st.raw = raw_q;
  assign st.rawNext = raw_d;

  // An event in the clear cycle leaves the bit set.
  a_set_beats_clear: assert property (@(posedge core_clk) disable iff (rst)
    (st.evtSet & st.clrHit) != '0 |=> (raw_q & $past(st.evtSet)) == $past(st.evtSet))
    else $error("event lost under clear");

  // A set bit without a clear or event stays set.
  a_no_clear_holds: assert property (@(posedge core_clk) disable iff (rst)
    (raw_q & ~st.clrHit) != '0 |=> (raw_q & $past(raw_q & ~st.clrHit)) == $past(raw_q & ~st.clrHit))
    else $error("status dropped without clear");

endmodule

// *** verif/uic_evt_src.sv ***
// Model of the UART datapath that raises interrupt events.
// Assumes the bench asks for events by non-blocking writes after a clock edge.
`timescale 1ns/1ps
module uic_evt_src (
  input wire logic core_clk,
  input wire logic [6:0] fireReq,
  output logic [6:0] evtPulse
);
  // Request seen at the previous edge.
  logic [6:0] lastReq_q;

  // A held request must not become a stream of events, so only new bits pass.
  always_comb begin
    evtPulse = fireReq & ~lastReq_q;
  end

  // Remember the request for the edge detection.
  always_ff @(posedge core_clk) begin
    lastReq_q <= fireReq;
  end
endmodule

// *** verif/uic_irq_clear_id_tb.sv ***
// Self-checking bench for the interrupt clear and identification block.
// Assumes the package and design files under hw/ are compiled first.
`timescale 1ns/1ps
module uic_irq_clear_id_tb;
  // Identifier handed to the design; the value is arbitrary.
  localparam logic [31:0] ID_VAL = 32'hC3A5_1E69;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [31:0] regRdData;
  logic [6:0] fireReq = 7'h00;
  logic [6:0] evtPulse;
  logic [6:0] intMask;
  logic irqOut;
  int num_errors = 0;
  int cmp_count = 0;
  // Clear word of each row and the raw status it should leave behind.
  logic [31:0] clrV [8];
  logic [31:0] rawV [8];

  // Free-running 50 MHz clock.
  always #10 core_clk = ~core_clk;

  uic_evt_src u_src (.core_clk(core_clk), .fireReq(fireReq), .evtPulse(evtPulse));

  uic_irq_clear_id #(.PERIPH_ID(ID_VAL), .EVT_N(7)) DUT (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .evtPulse(evtPulse), .intMask(intMask), .irqOut(irqOut));

  // Compare one value and count it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  // One-cycle read; data are valid only in the following cycle.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 chk(regRdData, exp, "read data");
  endtask

  // Ask the event model for one pulse on the given sources.
  task automatic fire(input logic [6:0] v);
    @(posedge core_clk);
    fireReq <= v;
    @(posedge core_clk);
    fireReq <= 7'h00;
  endtask

  // Status and output checks after a reset.
  task automatic chk_reset();
    @(posedge core_clk);
    #1 chk({25'h0, intMask}, 32'h0000_0000, "mask out");
    chk({31'h0, irqOut}, 32'h0000_0000, "irq");
    rd(uic_pkg::OFF_RAW, 32'h0000_000F);
    rd(uic_pkg::OFF_MASKED, 32'h0000_0000);
    rd(uic_pkg::OFF_MASK, 32'h0000_0000);
  endtask

  // Single place where the run ends.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: the tests need about 110 cycles.
  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    clrV = '{32'h0000_0000, 32'h0000_0400, 32'h0000_0200, 32'h0000_0100,
             32'h0000_0080, 32'h0000_0040, 32'h0000_0020, 32'h0000_0010};
    rawV = '{32'h0000_07FF, 32'h0000_03FF, 32'h0000_01FF, 32'h0000_00FF,
             32'h0000_007F, 32'h0000_003F, 32'h0000_001F, 32'h0000_000F};
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    chk_reset();
    $display("test reset done");
    // All sources set and enabled, then cleared one field at a time.
    wr(uic_pkg::OFF_MASK, 32'h0000_07F0);
    #1 chk({25'h0, intMask}, 32'h0000_007F, "mask out");
    fire(7'h7F);
    for (int r = 0; r < 8; r++) begin
      wr(uic_pkg::OFF_CLEAR, clrV[r]);
      #1 chk({31'h0, irqOut}, {31'h0, |rawV[r][10:4]}, "irq");
      rd(uic_pkg::OFF_RAW, rawV[r]);
      rd(uic_pkg::OFF_MASKED, rawV[r] & 32'h0000_07F0);
    end
    $display("test clear rows done");
    // A disabled source stays in raw status only; status writes are ignored.
    wr(uic_pkg::OFF_MASK, 32'h0000_0000);
    fire(7'h01);
    rd(uic_pkg::OFF_MASKED, 32'h0000_0000);
    chk({31'h0, irqOut}, 32'h0000_0000, "irq");
    wr(uic_pkg::OFF_RAW, 32'h0000_0000);
    wr(uic_pkg::OFF_MASKED, 32'h0000_0000);
    rd(uic_pkg::OFF_RAW, 32'h0000_001F);
    wr(uic_pkg::OFF_MASK, 32'h0000_0010);
    #1 chk({31'h0, irqOut}, 32'h0000_0001, "irq");
    rd(uic_pkg::OFF_MASKED, 32'h0000_0010);
    $display("test masking done");
    // Event in the same cycle as its clear must survive.
    @(posedge core_clk);
    fireReq <= 7'h40;
    regAddr <= uic_pkg::OFF_CLEAR;
    regWrData <= 32'h0000_0410;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    fireReq <= 7'h00;
    regWrEn <= 1'b0;
    rd(uic_pkg::OFF_RAW, 32'h0000_040F);
    chk({31'h0, irqOut}, 32'h0000_0000, "irq");
    $display("test set against clear done");
    // Identification bytes, a write to them, clear and unmapped reads.
    for (int k = 0; k < 4; k++) begin
      rd(uic_pkg::OFF_ID4 + 12'(4 * k), {24'h0, ID_VAL[8 * k +: 8]});
    end
    wr(uic_pkg::OFF_ID4, 32'h0000_00FF);
    rd(uic_pkg::OFF_ID4, {24'h0, ID_VAL[7:0]});
    rd(uic_pkg::OFF_CLEAR, 32'h0000_0000);
    rd(12'h100, 32'h0000_0000);
    $display("test identification done");
    // Second reset with status pending.
    wr(uic_pkg::OFF_MASK, 32'h0000_07F0);
    fire(7'h7F);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    chk_reset();
    $display("test second reset done");
    end_sim();
  end
endmodule
